// [core/ssw_pkg.sv]
package ssw_pkg;
  // ----------------------------------------
  // time base
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // reset stretch, warning pulse, warning filter, watchdog period, debounce
  localparam int unsigned RST_STRETCH_MS = 130;
  localparam int unsigned WARN_PULSE_US = 200;
  localparam int unsigned WARN_FILTER_US = 5;
  localparam int unsigned WDOG_PERIOD_S = 1;
  localparam int unsigned WDOG_LOW_MS = 130;
  localparam int unsigned DEBOUNCE_US = 1000;
  // minimum times convert to whole cycles through truncating integer division
  localparam int unsigned RST_STRETCH_CYC = RST_STRETCH_MS * (CLK_HZ / 1000);
  localparam int unsigned WARN_PULSE_CYC = WARN_PULSE_US * (CLK_HZ / 1000000);
  localparam int unsigned WARN_FILTER_CYC = WARN_FILTER_US * (CLK_HZ / 1000000);
  localparam int unsigned WDOG_PERIOD_CYC = WDOG_PERIOD_S * CLK_HZ;
  localparam int unsigned WDOG_LOW_CYC = WDOG_LOW_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------
  // grouped pin carriers
  // ----------------------------------------
  typedef struct packed {
    logic supplyLow;
    logic senseLow;
    logic manualResetN;
    logic strobeN;
  } ssw_in_t;

  typedef struct packed {
    logic systemResetN;
    logic powerFailWarnN;
    logic watchdogExpiryN;
  } ssw_out_t;

  typedef enum logic [1:0] {RS_HOLD, RS_STRETCH, RS_RUN} ssw_rst_state_t;
endpackage : ssw_pkg

// [core/ssw_timer.sv]
// ----------------------------------------
// timeout counter: counts while run, clears on clear or stop
// ----------------------------------------
module ssw_timer #(
  parameter int unsigned LIMIT = 100
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clockEnable,
  input wire logic run,
  input wire logic clear,
  output logic done
);
  logic [ssw_pkg::CNT_W-1:0] count_reg;

  // count up to limit then hold done
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else if (clockEnable) begin
      if (clear || !run) begin
        count_reg <= '0;
      end else if (count_reg < ssw_pkg::CNT_W'(LIMIT)) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  assign done = run && !clear && (count_reg >= ssw_pkg::CNT_W'(LIMIT));
endmodule // ssw_timer

// [core/ssw_supervisor.sv]
module ssw_supervisor #(
  parameter int unsigned RST_STRETCH_CYC = ssw_pkg::RST_STRETCH_CYC,
  parameter int unsigned WARN_PULSE_CYC = ssw_pkg::WARN_PULSE_CYC,
  parameter int unsigned WARN_FILTER_CYC = ssw_pkg::WARN_FILTER_CYC,
  parameter int unsigned WDOG_PERIOD_CYC = ssw_pkg::WDOG_PERIOD_CYC,
  parameter int unsigned WDOG_LOW_CYC = ssw_pkg::WDOG_LOW_CYC,
  parameter int unsigned DEBOUNCE_CYC = ssw_pkg::DEBOUNCE_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clockEnable,
  input wire ssw_pkg::ssw_in_t pins,
  output ssw_pkg::ssw_out_t outs
);
  // ----------------------------------------
  // manual reset debounce
  // ----------------------------------------
  logic manualLow_reg;
  logic strobePrev_reg;
  logic pinsDiffer;
  logic debounceDone;
  logic strobeFall;

  assign pinsDiffer = (pins.manualResetN == manualLow_reg);
  assign strobeFall = strobePrev_reg && !pins.strobeN;

  ssw_timer #(.LIMIT(DEBOUNCE_CYC)) debounceTimer (
    .clock(clock), .rstn(rstn), .clockEnable(clockEnable),
    .run(pinsDiffer), .clear(1'b0), .done(debounceDone)
  );

  // accept new level after it holds stable for the debounce time
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      manualLow_reg <= 1'b0;
    end else if (clockEnable && debounceDone) begin
      manualLow_reg <= !pins.manualResetN;
    end
  end

  // strobe edge history
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strobePrev_reg <= 1'b1;
    end else if (clockEnable) begin
      strobePrev_reg <= pins.strobeN;
    end
  end

  // ----------------------------------------
  // system reset sequencing
  // ----------------------------------------
  ssw_pkg::ssw_rst_state_t rstState_reg;
  logic resetCause;
  logic stretchDone;

  assign resetCause = pins.supplyLow || manualLow_reg;

  ssw_timer #(.LIMIT(RST_STRETCH_CYC)) stretchTimer (
    .clock(clock), .rstn(rstn), .clockEnable(clockEnable),
    .run(rstState_reg == ssw_pkg::RS_STRETCH), .clear(resetCause), .done(stretchDone)
  );

  // hold, then stretch from release, then run
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstState_reg <= ssw_pkg::RS_HOLD;
    end else if (clockEnable) begin
      case (rstState_reg)
        ssw_pkg::RS_HOLD: begin
          if (!resetCause) begin
            rstState_reg <= ssw_pkg::RS_STRETCH;
          end
        end
        ssw_pkg::RS_STRETCH: begin
          if (resetCause) begin
            rstState_reg <= ssw_pkg::RS_HOLD;
          end else if (stretchDone) begin
            rstState_reg <= ssw_pkg::RS_RUN;
          end
        end
        ssw_pkg::RS_RUN: begin
          if (resetCause) begin
            rstState_reg <= ssw_pkg::RS_HOLD;
          end
        end
        default: rstState_reg <= ssw_pkg::RS_HOLD;
      endcase
    end
  end

  logic systemResetN_reg;

  // reset output registered from state and reset cause
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      systemResetN_reg <= 1'b0;
    end else if (clockEnable) begin
      systemResetN_reg <= (rstState_reg == ssw_pkg::RS_RUN) && !resetCause;
    end
  end

  // ----------------------------------------
  // power-fail warning
  // ----------------------------------------
  logic supplyReached_reg;
  logic warnActive_reg;
  logic warnN_reg;
  logic filterDone;
  logic pulseDone;

  // gate warning while the supply was below its trip level last cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      supplyReached_reg <= 1'b0;
    end else if (clockEnable) begin
      supplyReached_reg <= !pins.supplyLow;
    end
  end

  ssw_timer #(.LIMIT(WARN_FILTER_CYC)) filterTimer (
    .clock(clock), .rstn(rstn), .clockEnable(clockEnable),
    .run(pins.senseLow && supplyReached_reg && !warnActive_reg), .clear(1'b0), .done(filterDone)
  );

  ssw_timer #(.LIMIT(WARN_PULSE_CYC)) pulseTimer (
    .clock(clock), .rstn(rstn), .clockEnable(clockEnable),
    .run(warnActive_reg), .clear(1'b0), .done(pulseDone)
  );

  // one pulse per trip; rearm only after sense goes high again
  logic warnArmed_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      warnActive_reg <= 1'b0;
      warnArmed_reg <= 1'b1;
    end else if (clockEnable) begin
      if (warnActive_reg) begin
        if (pulseDone) begin
          warnActive_reg <= 1'b0;
        end
      end else if (filterDone && warnArmed_reg) begin
        warnActive_reg <= 1'b1;
        warnArmed_reg <= 1'b0;
      end else if (!pins.senseLow) begin
        warnArmed_reg <= 1'b1;
      end
    end
  end

  // warning output flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      warnN_reg <= 1'b1;
    end else if (clockEnable) begin
      warnN_reg <= !(warnActive_reg && !pulseDone);
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  logic wdogRun;
  logic wdogExpired;
  logic wdogLow_reg;
  logic wdogLowDone;
  logic wdogN_reg;

  assign wdogRun = systemResetN_reg && !wdogLow_reg;

  ssw_timer #(.LIMIT(WDOG_PERIOD_CYC)) wdogTimer (
    .clock(clock), .rstn(rstn), .clockEnable(clockEnable),
    .run(wdogRun), .clear(strobeFall), .done(wdogExpired)
  );

  ssw_timer #(.LIMIT(WDOG_LOW_CYC)) wdogLowTimer (
    .clock(clock), .rstn(rstn), .clockEnable(clockEnable),
    .run(wdogLow_reg), .clear(1'b0), .done(wdogLowDone)
  );

  // expiry holds output low for the minimum time
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wdogLow_reg <= 1'b0;
    end else if (clockEnable) begin
      if (wdogLow_reg) begin
        if (wdogLowDone) begin
          wdogLow_reg <= 1'b0;
        end
      end else if (wdogExpired) begin
        wdogLow_reg <= 1'b1;
      end
    end
  end

  // watchdog output flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wdogN_reg <= 1'b1;
    end else if (clockEnable) begin
      wdogN_reg <= !((wdogLow_reg && !wdogLowDone) || (!wdogLow_reg && wdogExpired));
    end
  end

  assign outs.systemResetN = systemResetN_reg;
  assign outs.powerFailWarnN = warnN_reg;
  assign outs.watchdogExpiryN = wdogN_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_supply_low_reset: assert property (@(posedge clock) disable iff (!rstn)
    (clockEnable && pins.supplyLow) |=> !outs.systemResetN)
    else $error("reset not asserted on low supply");
  a_manual_hold_reset: assert property (@(posedge clock) disable iff (!rstn)
    (clockEnable && manualLow_reg) |=> !outs.systemResetN)
    else $error("reset released while manual reset held");
  a_release_stretch: assert property (@(posedge clock) disable iff (!rstn)
    $rose(outs.systemResetN) |-> $past(stretchDone, 2))
    else $error("reset released before stretch");
  a_stretch_from_release: assert property (@(posedge clock) disable iff (!rstn)
    (clockEnable && rstState_reg == ssw_pkg::RS_HOLD && !resetCause) |=> rstState_reg == ssw_pkg::RS_STRETCH)
    else $error("stretch did not start on release");
  a_warn_filter: assert property (@(posedge clock) disable iff (!rstn)
    $rose(warnActive_reg) |-> $past(filterDone))
    else $error("warning without filtered sense");
  a_warn_gate: assert property (@(posedge clock) disable iff (!rstn)
    $fell(outs.powerFailWarnN) |-> $past(supplyReached_reg, 2))
    else $error("warning filter ran before supply trip");
  a_warn_pulse: assert property (@(posedge clock) disable iff (!rstn)
    $fell(outs.powerFailWarnN) && clockEnable |=> !outs.powerFailWarnN)
    else $error("warning pulse too short");
  a_wdog_in_reset: assert property (@(posedge clock) disable iff (!rstn)
    (clockEnable && !outs.systemResetN) |=> (wdogTimer.count_reg == '0))
    else $error("watchdog ran during reset");
  a_wdog_strobe: assert property (@(posedge clock) disable iff (!rstn)
    (clockEnable && strobeFall) |=> (wdogTimer.count_reg == '0))
    else $error("strobe did not restart watchdog");
  a_wdog_low: assert property (@(posedge clock) disable iff (!rstn)
    $rose(wdogLow_reg) |-> !outs.watchdogExpiryN)
    else $error("watchdog output not low on expiry");
endmodule // ssw_supervisor

// [sim/ssw_host_model.sv]
// ----------------------------------------
// host processor: strobes the watchdog
// ----------------------------------------
module ssw_host_model #(
  parameter int PERIOD = 30
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic systemResetN,
  input wire logic enable,
  output logic strobeN
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // one low cycle every PERIOD cycles, only while out of reset, driven on the falling edge
  always @(negedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt = 0;
      strobeN <= 1'b1;
    end else if (enable && systemResetN) begin
      cnt = cnt + 1;
      strobeN <= ((cnt % PERIOD) != 0);
    end else begin
      cnt = 0;
      strobeN <= 1'b1;
    end
  end
endmodule // ssw_host_model

// [sim/tb_ssw_supervisor.sv]
module tb_ssw_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST = 20, WP = 10, WF = 4, WD = 50, WL = 10, DB = 3;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic supplyLow = 1'b0;
  logic senseLow = 1'b0;
  logic manualN = 1'b1;
  logic hostOn = 1'b0;
  logic loopOn = 1'b0;
  logic clkEn = 1'b1;
  logic hostStrobeN;
  ssw_pkg::ssw_in_t pins;
  ssw_pkg::ssw_out_t outs;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int lastStrobe = 0;
  int n;
  int k;
  // expiry may be looped back into the manual reset input
  assign pins = {supplyLow, senseLow, loopOn ? outs.watchdogExpiryN : manualN, hostStrobeN};
  always #5 clock = ~clock;
  // strobe timestamps for the watchdog model
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (pins.strobeN === 1'b0) lastStrobe <= cyc;
  end
  ssw_supervisor #(.RST_STRETCH_CYC(RST), .WARN_PULSE_CYC(WP), .WARN_FILTER_CYC(WF),
    .WDOG_PERIOD_CYC(WD), .WDOG_LOW_CYC(WL), .DEBOUNCE_CYC(DB)) i_dut (
    .clock(clock), .rstn(rstn), .clockEnable(clkEn), .pins(pins), .outs(outs));
  ssw_host_model #(.PERIOD(30)) i_host (
    .clock(clock), .rstn(rstn), .systemResetN(outs.systemResetN), .enable(hostOn), .strobeN(hostStrobeN));
  // ----------------------------------------
  // compare helpers
  // ----------------------------------------
  function automatic logic ob(input int w);
    case (w)
      0: return outs.systemResetN;
      1: return outs.powerFailWarnN;
      default: return outs.watchdogExpiryN;
    endcase
  endfunction
  task automatic check_lvl(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic check_rng(input int got, input int lo, input int hi, input string msg);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: %s (%0d)", $time, msg, got);
    end
  endtask
  // wait for an output level, counting cycles
  task automatic wait_lvl(input int w, input logic v, input int maxc, output int c);
    c = 0;
    while (ob(w) !== v && c < maxc) begin
      @(negedge clock);
      c++;
    end
    check_lvl(ob(w), v, "output level not reached");
  endtask
  // output must stay at a level for c cycles
  task automatic hold_chk(input int w, input logic v, input int c, input string msg);
    repeat (c) begin
      @(negedge clock);
      check_lvl(ob(w), v, msg);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h36bd479d));
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    hostOn <= 1'b1;
    wait_lvl(0, 1'b1, 300, n);
    check_rng(n, RST, RST + DB + 10, "power-up stretch");
    // supply drop with sense low: reset, no warning
    supplyLow = 1'b1;
    senseLow = 1'b1;
    repeat (2) @(negedge clock);
    check_lvl(ob(0), 1'b0, "no reset on low supply");
    hold_chk(1, 1'b1, WF + 16, "warning while supply low");
    senseLow = 1'b0;
    @(negedge clock);
    // frozen clock enable keeps reset held after supply returns
    clkEn = 1'b0;
    supplyLow = 1'b0;
    hold_chk(0, 1'b0, RST + 10, "reset moved while frozen");
    clkEn = 1'b1;
    wait_lvl(0, 1'b1, 300, n);
    check_rng(n, RST, RST + DB + 10, "supply return stretch");
    // bounce shorter than the filter
    manualN = 1'b0;
    @(negedge clock);
    manualN = 1'b1;
    hold_chk(0, 1'b1, 20, "bounce accepted");
    // held press of random length
    k = 10 + $urandom_range(30, 0);
    manualN = 1'b0;
    wait_lvl(0, 1'b0, DB + 6, n);
    hold_chk(0, 1'b0, k, "reset released during press");
    manualN = 1'b1;
    wait_lvl(0, 1'b1, 300, n);
    check_rng(n, RST, RST + DB + 10, "stretch not from release");
    // sense dip shorter than the filter
    senseLow = 1'b1;
    repeat ($urandom_range(WF - 1, 1)) @(negedge clock);
    senseLow = 1'b0;
    hold_chk(1, 1'b1, 20, "warning on short dip");
    senseLow = 1'b1;
    wait_lvl(1, 1'b0, WF + 8, n);
    check_rng(n, WF, WF + 8, "warning filter");
    wait_lvl(1, 1'b1, WP + 20, n);
    check_rng(n, WP, WP + 3, "warning pulse width");
    senseLow = 1'b0;
    // watchdog held off during reset, then expires
    hostOn <= 1'b0;
    supplyLow = 1'b1;
    hold_chk(2, 1'b1, WD + 30, "watchdog ran during reset");
    supplyLow = 1'b0;
    wait_lvl(0, 1'b1, 300, n);
    wait_lvl(2, 1'b0, WD + 20, n);
    check_rng(n, WD - 1, WD + 5, "watchdog period after reset");
    wait_lvl(2, 1'b1, WL + 20, n);
    check_rng(n, WL, WL + 5, "watchdog low time");
    // regular strobes keep it quiet, then stop
    hostOn <= 1'b1;
    hold_chk(2, 1'b1, 3 * WD, "watchdog expired while strobed");
    hostOn <= 1'b0;
    wait_lvl(2, 1'b0, WD + 40, n);
    check_rng(cyc - lastStrobe, WD, WD + 5, "watchdog period after strobe");
    // reset in mid-run returns all outputs to their reset levels, then a full stretch
    rstn = 1'b0;
    @(negedge clock);
    check_lvl(ob(0), 1'b0, "reset output high during reset");
    check_lvl(ob(1), 1'b1, "warning active during reset");
    check_lvl(ob(2), 1'b1, "watchdog output low during reset");
    rstn = 1'b1;
    wait_lvl(0, 1'b1, 300, n);
    check_rng(n, RST, RST + DB + 10, "stretch after mid-run reset");
    // expiry looped into manual reset gives a full system reset
    loopOn = 1'b1;
    wait_lvl(2, 1'b0, WD + 20, n);
    wait_lvl(0, 1'b0, DB + 6, n);
    check_rng(n, DB + 1, DB + 3, "looped expiry reset delay");
    wait_lvl(0, 1'b1, RST + WL + 40, n);
    check_rng(n, RST, RST + WL + DB + 10, "looped reset stretch");
    loopOn = 1'b0;
    finish_test();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
endmodule // tb_ssw_supervisor
